/* hw/frame_dma_consts.svh */
// frame dma engine register offsets, field positions and reset values
`ifndef FRAME_DMA_CONSTS_SVH
`define FRAME_DMA_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets, and address bits 7:5 of the channel registers
// ----------------------------------------------------------------------
`define OFS_GLOBAL 8'h00
`define OFS_PORTCFG 8'h04
`define OFS_GAP 8'h08
`define OFS_MANUAL 8'h0c
`define OFS_STATUS 8'h10
`define OFS_CHAN_BASE 3'h1
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GLB_MANUAL 0
`define GLB_WM_LSB 8
`define PCFG_HDR_INS 0
`define PCFG_INJ_HDR 2
`define PCFG_FCS 4
`define PCFG_XTR_OWN 6
`define PCFG_INJ_OWN 8
`define STAT_SOF 16
`define STAT_EOF 17
`define STAT_OFS_LSB 20
// ----------------------------------------------------------------------
// reset values and control block status word offset
// ----------------------------------------------------------------------
`define RST_WM 8'h00
`define RST_PORTCFG 10'h030
`define RST_GAPS 8'h00
`define CB_STATUS_OFS 32'h0000000c

`endif

/* hw/frame_dma_pkg.sv */
// frame dma engine shared types
package frame_dma_pkg;

  // descriptor walker states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_MOVE = 5'b00100,
    ST_STAT = 5'b01000,
    ST_ADV = 5'b10000
  } fsm_t;

endpackage

/* hw/frame_dma_arbiter.sv */
// strict priority channel picker, ties go to the higher channel
`timescale 1ns/1ps
`default_nettype none
module frame_dma_arbiter
  import frame_dma_pkg::*;
#(
  parameter int N = 4,
  parameter int PW = 3
)
(
  // clock for checks only
  input wire logic clk_sys,
  input wire logic rst,
  // requests and their priorities
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][PW-1:0] prio,
  // decision
  output logic gntValid,
  output logic [$clog2(N)-1:0] gnt
);

  logic [PW-1:0] best; // priority of the current pick

  // ascending scan with >= lets a later (higher) channel win a tie
  always_comb
  begin
    gntValid = 1'b0;
    gnt = '0;
    best = '0;
    for (int i = 0; i < N; i++)
    begin
      if (req[i] && (!gntValid || prio[i] >= best))
      begin
        gntValid = 1'b1;
        gnt = i[$clog2(N)-1:0];
        best = prio[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic beaten; // some other requester should have won
  always_comb
  begin
    beaten = 1'b0;
    for (int i = 0; i < N; i++)
      if (req[i] && (prio[i] > prio[gnt] || (prio[i] == prio[gnt] && i > int'(gnt))))
        beaten = 1'b1;
  end

  property p_strict;
    @(posedge clk_sys) disable iff (rst) gntValid |-> !beaten && req[gnt];
  endproperty
  a_strict: assert property (p_strict) else $error("arbiter picked a weaker channel");

  property p_anyreq;
    @(posedge clk_sys) disable iff (rst) (|req) |-> gntValid;
  endproperty
  a_anyreq: assert property (p_anyreq) else $error("request left without grant");

endmodule
`default_nettype wire

/* hw/frame_dma_engine.sv */
// frame dma engine: register slave, control block walker and byte mover
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Behaviour
// - four channels, two extract, two inject
// - strict priority among requesting channels
// - equal priority, higher channel number wins
// - header insert enable per extraction port
// - injection header enable per port
// - checksum rewrite on injection unless disabled
// - manual mode serves only requested channels, by priority
// - same control block walk both directions
// - one frame per buffer at most
// - start and end flags in status word
// - frame byte n below byte n+1
// - offset plus length fits in buffer
// - extraction writes computed length back
// - word zero is next pointer, null ends
// - status holds count and byte offset
// - status bit sixteen marks frame start
// ----------------------------------------------------------------------
`include "frame_dma_consts.svh"
module frame_dma_engine
  import frame_dma_pkg::*;
#(
  parameter int PRIO_W = 3
)
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory master, one word access per request
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  output logic [3:0] memBe,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  // extraction byte streams, one per cpu port
  input wire logic [1:0] xtrValid,
  input wire logic [15:0] xtrData,
  input wire logic [1:0] xtrEof,
  output logic [1:0] xtrReady,
  // injection byte stream toward the queues
  output logic [1:0] injValid,
  output logic [7:0] injData,
  output logic injSof,
  output logic injEof,
  input wire logic [1:0] injReady,
  // per-port controls toward the queue system
  output logic [1:0] xtrHeaderInsert,
  output logic [1:0] injHeaderPresent,
  output logic [1:0] injFcsRewrite,
  output logic [3:0] injGap0,
  output logic [3:0] injGap1,
  output logic [7:0] injWatermark
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ahbWrite; // write data phase pending
    logic [7:0] ahbAddr; // latched address phase
    logic [31:0] rdata; // read data for the data phase
    logic manual; // manual mode
    logic [7:0] watermark; // injection buffer watermark
    logic [9:0] portCfg; // per-port enables and ownership
    logic [7:0] gaps; // injection gap sizes
    logic [3:0][31:0] head; // current control block per channel
    logic [3:0][PRIO_W-1:0] prio; // channel priority field
    logic [3:0] armed; // channel has a list to walk
    logic [3:0] inFrame; // a frame is open across buffers
    logic [3:0] manualPend; // manual requests not yet served
    fsm_t fsm; // walker state
    logic [1:0] chan; // channel being served
    logic [1:0] idx; // control block word index
    logic [31:0] nextPtr; // fetched next block pointer
    logic [31:0] bufPtr; // fetched buffer pointer
    logic [15:0] size; // buffer size in bytes
    logic [11:0] offset; // frame byte offset in buffer
    logic [15:0] len; // injection byte length
    logic sof; // buffer starts a frame
    logic eof; // buffer ends a frame
    logic [15:0] count; // bytes moved in this buffer
    logic req; // memory request
    logic wr; // memory write
    logic [31:0] addr; // memory address
    logic [31:0] wdata; // memory write data
    logic [3:0] be; // memory byte enables
    logic iValid; // injection byte waiting
    logic [7:0] iData; // injection byte
    logic iSof; // injection byte opens a frame
    logic iEof; // injection byte closes a frame
  } state_t;

  state_t s; // registered state
  state_t next_s; // next state

  // ----------------------------------------------------------------------
  // channel decode and arbitration
  // ----------------------------------------------------------------------
  logic [3:0] want; // channels needing service
  logic [3:0] req; // channels offered to the picker
  logic gntValid; // picker found a channel
  logic [1:0] gnt; // picked channel
  logic port; // cpu port of the served channel
  logic isXtr; // served channel extracts
  logic [15:0] byteIdx; // byte position inside the buffer
  logic [31:0] byteAddr; // memory byte address of that position
  logic [1:0] lane; // byte lane of that position
  logic [7:0] xtrByte; // byte offered by the served port

  // channels 0/1 extract from ports 11/12, 2/3 inject to them
  assign want[0] = s.armed[0] && s.portCfg[`PCFG_XTR_OWN] && xtrValid[0];
  assign want[1] = s.armed[1] && s.portCfg[`PCFG_XTR_OWN+1] && xtrValid[1];
  assign want[2] = s.armed[2] && s.portCfg[`PCFG_INJ_OWN];
  assign want[3] = s.armed[3] && s.portCfg[`PCFG_INJ_OWN+1];

  // manual mode keeps priority: only requested channels may go
  assign req = s.manual ? (want & s.manualPend) : want;

  assign port = s.chan[0];
  assign isXtr = !s.chan[1];
  assign byteIdx = {4'h0, s.offset} + s.count;
  assign byteAddr = s.bufPtr + {16'h0, byteIdx};
  assign lane = byteAddr[1:0];
  assign xtrByte = port ? xtrData[15:8] : xtrData[7:0];

  frame_dma_arbiter #(
    .N(4),
    .PW(PRIO_W)
  ) u_arb (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(req),
    .prio(s.prio),
    .gntValid(gntValid),
    .gnt(gnt)
  );

  // ----------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------
  function automatic logic [31:0] regRead(input state_t st, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a[7:5] == `OFS_CHAN_BASE)
      v = a[2] ? 32'(st.prio[a[4:3]]) : st.head[a[4:3]];
    else
      unique case (a)
        `OFS_GLOBAL: v = {16'h0, st.watermark, 7'h0, st.manual};
        `OFS_PORTCFG: v = {22'h0, st.portCfg};
        `OFS_GAP: v = {24'h0, st.gaps};
        `OFS_MANUAL: v = {28'h0, st.manualPend};
        `OFS_STATUS: v = {11'h0, st.fsm, 2'h0, st.chan, st.manualPend, st.inFrame, st.armed};
        default: v = 32'h0; // unmapped reads as zero
      endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // engine first, so a software write in the same cycle wins
    unique case (s.fsm)
      ST_IDLE:
      begin
        if (gntValid)
        begin
          // walk starts at word zero of the current block
          next_s.chan = gnt;
          next_s.idx = 2'h0;
          next_s.req = 1'b1;
          next_s.wr = 1'b0;
          next_s.be = 4'hf;
          next_s.addr = s.head[gnt];
          next_s.manualPend[gnt] = 1'b0;
          next_s.fsm = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (memAck)
        begin
          unique case (s.idx)
            2'h0: next_s.nextPtr = memRdata;
            2'h1: next_s.bufPtr = memRdata;
            2'h2: next_s.size = memRdata[15:0];
            2'h3:
            begin
              next_s.offset = memRdata[31:`STAT_OFS_LSB];
              next_s.len = memRdata[15:0];
              // extraction decides its own flags while moving
              next_s.sof = isXtr ? 1'b0 : memRdata[`STAT_SOF];
              next_s.eof = isXtr ? 1'b0 : memRdata[`STAT_EOF];
            end
          endcase
          next_s.idx = s.idx + 2'h1;
          next_s.addr = s.addr + 32'h4;
          if (s.idx == 2'h3)
          begin
            next_s.req = 1'b0;
            next_s.count = 16'h0;
            next_s.fsm = ST_MOVE;
          end
        end
      end
      ST_MOVE:
      begin
        if (isXtr)
        begin
          if (s.req)
          begin
            if (memAck)
            begin
              // byte stored: it is consumed from the port this cycle
              next_s.req = 1'b0;
              next_s.count = s.count + 16'h1;
              next_s.eof = xtrEof[port];
              next_s.inFrame[s.chan] = !xtrEof[port];
              if (s.count == 16'h0)
                next_s.sof = !s.inFrame[s.chan];
            end
          end
          else if (s.eof || byteIdx >= s.size)
          begin
            // frame ended or buffer full: close it, never mix frames
            next_s.req = 1'b1;
            next_s.wr = 1'b1;
            next_s.be = 4'hf;
            next_s.addr = s.head[s.chan] + `CB_STATUS_OFS;
            next_s.wdata = {s.offset, 2'h0, s.eof, s.sof, s.count};
            next_s.fsm = ST_STAT;
          end
          else if (xtrValid[port])
          begin
            // one byte per access keeps any offset legal
            next_s.req = 1'b1;
            next_s.wr = 1'b1;
            next_s.addr = {byteAddr[31:2], 2'h0};
            next_s.be = 4'h1 << lane;
            next_s.wdata = {4{xtrByte}};
          end
        end
        else
        begin
          if (s.iValid)
          begin
            if (injReady[port])
            begin
              next_s.iValid = 1'b0;
              next_s.count = s.count + 16'h1;
            end
          end
          else if (s.count == s.len)
            next_s.fsm = ST_ADV;
          else if (!s.req)
          begin
            // fetch the word holding the next byte
            next_s.req = 1'b1;
            next_s.wr = 1'b0;
            next_s.addr = {byteAddr[31:2], 2'h0};
            next_s.be = 4'hf;
          end
          else if (memAck)
          begin
            next_s.req = 1'b0;
            next_s.iValid = 1'b1;
            next_s.iData = 8'(memRdata >> {lane, 3'h0});
            next_s.iSof = s.sof && s.count == 16'h0;
            next_s.iEof = s.eof && s.count == s.len - 16'h1;
          end
        end
      end
      ST_STAT:
      begin
        if (memAck)
        begin
          next_s.req = 1'b0;
          next_s.wr = 1'b0;
          next_s.fsm = ST_ADV;
        end
      end
      ST_ADV:
      begin
        // follow the list; a null pointer parks the channel
        next_s.head[s.chan] = s.nextPtr;
        if (s.nextPtr == 32'h0)
          next_s.armed[s.chan] = 1'b0;
        next_s.fsm = ST_IDLE;
      end
    endcase
    // ahb-lite data phase write
    if (s.ahbWrite)
    begin
      if (s.ahbAddr[7:5] == `OFS_CHAN_BASE)
      begin
        if (s.ahbAddr[2])
          next_s.prio[s.ahbAddr[4:3]] = hwdata[PRIO_W-1:0];
        else
        begin
          // new list head; a nonzero pointer arms the channel
          next_s.head[s.ahbAddr[4:3]] = {hwdata[31:2], 2'h0};
          next_s.armed[s.ahbAddr[4:3]] = |hwdata[31:2];
        end
      end
      else
        unique case (s.ahbAddr)
          `OFS_GLOBAL:
          begin
            next_s.manual = hwdata[`GLB_MANUAL];
            next_s.watermark = hwdata[`GLB_WM_LSB +: 8];
          end
          `OFS_PORTCFG: next_s.portCfg = hwdata[9:0];
          `OFS_GAP: next_s.gaps = hwdata[7:0];
          // keep the engine's clear of a served channel; only written bits are set again
          `OFS_MANUAL: next_s.manualPend = next_s.manualPend | hwdata[3:0];
          default: next_s.ahbWrite = 1'b0; // unmapped write ignored
        endcase
    end
    // ahb-lite address phase
    next_s.ahbWrite = hsel && htrans[1] && hready && hwrite;
    next_s.ahbAddr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
      next_s.rdata = regRead(s, haddr[7:0]);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.watermark <= `RST_WM;
      s.portCfg <= `RST_PORTCFG;
      s.gaps <= `RST_GAPS;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign hrdata = s.rdata;
  assign memReq = s.req;
  assign memWrite = s.wr;
  assign memAddr = s.addr;
  assign memWdata = s.wdata;
  assign memBe = s.be;
  // a byte leaves the port only when its store completes
  assign xtrReady[0] = s.fsm == ST_MOVE && s.chan == 2'd0 && s.req && memAck;
  assign xtrReady[1] = s.fsm == ST_MOVE && s.chan == 2'd1 && s.req && memAck;
  assign injValid[0] = s.iValid && !port;
  assign injValid[1] = s.iValid && port;
  assign injData = s.iData;
  assign injSof = s.iSof;
  assign injEof = s.iEof;
  assign xtrHeaderInsert = s.portCfg[`PCFG_HDR_INS +: 2];
  assign injHeaderPresent = s.portCfg[`PCFG_INJ_HDR +: 2];
  assign injFcsRewrite = s.portCfg[`PCFG_FCS +: 2];
  assign injGap0 = s.gaps[3:0];
  assign injGap1 = s.gaps[7:4];
  assign injWatermark = s.watermark;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_lastByte;
    s.fsm == ST_MOVE && isXtr && s.req && memAck && xtrEof[port];
  endsequence
  sequence s_closeWrite;
    s.fsm == ST_STAT && s.wr && s.wdata[`STAT_EOF];
  endsequence

  property p_eofCloses;
    s_lastByte |=> (!s.req && s.fsm == ST_MOVE) ##1 s_closeWrite;
  endproperty
  a_eofCloses: assert property (p_eofCloses) else $error("buffer not closed after end of frame");

  property p_lenBack;
    s.fsm == ST_STAT |-> s.wdata[15:0] == s.count && s.wdata[31:20] == s.offset;
  endproperty
  a_lenBack: assert property (p_lenBack) else $error("status word count or offset wrong");

  property p_sofBack;
    s.fsm == ST_MOVE && isXtr && s.req && memAck && s.count == 16'h0 |=> s.sof == !$past(s.inFrame[s.chan]);
  endproperty
  a_sofBack: assert property (p_sofBack) else $error("start flag does not follow frame state");

  property p_nullStops;
    s.fsm == ST_ADV && s.nextPtr == 32'h0 && !s.ahbWrite |=> !s.armed[$past(s.chan)] && s.fsm == ST_IDLE;
  endproperty
  a_nullStops: assert property (p_nullStops) else $error("channel still armed after null pointer");

  property p_follow;
    s.fsm == ST_ADV && !s.ahbWrite |=> s.head[$past(s.chan)] == $past(s.nextPtr);
  endproperty
  a_follow: assert property (p_follow) else $error("list head not advanced");

  property p_manual;
    s.manual && s.fsm == ST_IDLE && gntValid |-> s.manualPend[gnt] ##1 !s.manualPend[s.chan];
  endproperty
  a_manual: assert property (p_manual) else $error("manual mode served an unrequested channel");

  property p_byteOrder;
    s.fsm == ST_MOVE && s.req && memAck && s.wr |=> ##[1:2] s.count == $past(s.count, 2) + 16'h1;
  endproperty
  a_byteOrder: assert property (p_byteOrder) else $error("byte position did not advance by one");

  property p_walk;
    s.fsm == ST_IDLE && gntValid |=> s.fsm == ST_FETCH && s.addr == $past(s.head[gnt]) && s.idx == 2'h0;
  endproperty
  a_walk: assert property (p_walk) else $error("walk did not start at list head");

  property p_xtrPort;
    xtrReady[0] |-> s.chan == 2'd0 && !xtrReady[1];
  endproperty
  a_xtrPort: assert property (p_xtrPort) else $error("extraction byte taken by wrong channel");

endmodule
`default_nettype wire

/* sim/frame_dma_mem_model.sv */
// memory partner: word memory with byte lanes, random answer delay
`timescale 1ns/1ps
`default_nettype none
module frame_dma_mem_model
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // word access port
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [3:0] memBe,
  output logic [31:0] memRdata,
  output logic memAck
);
  logic [31:0] mem [0:511]; // word image, loaded by the bench
  int waitCnt; // cycles left before the answer
  // ----------------------------------------------------------------------
  // answer after 0..3 idle cycles; read data is garbage outside the ack
  // ----------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata; // stale data is inverted on every cycle without an ack
    if (rst)
      waitCnt <= 0;
    else if (memReq && !memAck)
    begin
      if (waitCnt == 0)
      begin
        memAck <= 1'b1;
        waitCnt <= int'($urandom_range(3, 0));
        memRdata <= mem[memAddr[10:2]];
        for (int k = 0; k < 4; k++)
          if (memWrite && memBe[k])
            mem[memAddr[10:2]][8*k+:8] <= memWdata[8*k+:8]; // byte lane k
      end
      else
        waitCnt <= waitCnt - 1;
    end
  end
endmodule
`default_nettype wire

/* sim/frame_dma_channel_engine_tb.sv */
// bench for the frame dma engine: registers, injection and extraction walks
`timescale 1ns/1ps
`default_nettype none
module frame_dma_channel_engine_tb;
  logic clk_sys = 0, rst = 1, hwrite = 0, hready, hreadyout, hresp, memReq, memWrite, memAck, injSof, injEof;
  logic [1:0] htrans = 2'b00, xtrValid = 0, xtrEof = 0, xtrReady, injValid, injReady = 0;
  logic [1:0] hdrIns, injHdr, fcsRw;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, memAddr, memWdata, memRdata, rd, w;
  logic [15:0] xtrData = 0;
  logic [3:0] memBe, gap0, gap1;
  logic [7:0] injData, wm;
  logic [10:0] gotQ [$];
  int n_fail = 0, check_count = 0, cyc = 0;
  assign hready = hreadyout;
  frame_dma_engine i_dut (.clk_sys(clk_sys), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memBe(memBe), .memRdata(memRdata), .memAck(memAck), .xtrValid(xtrValid), .xtrData(xtrData),
    .xtrEof(xtrEof), .xtrReady(xtrReady), .injValid(injValid), .injData(injData), .injSof(injSof),
    .injEof(injEof), .injReady(injReady), .xtrHeaderInsert(hdrIns), .injHeaderPresent(injHdr),
    .injFcsRewrite(fcsRw), .injGap0(gap0), .injGap1(gap1), .injWatermark(wm));
  frame_dma_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .memBe(memBe), .memRdata(memRdata), .memAck(memAck));
  // ----------------------------------------------------------------------
  // clock, timeout, stalling queue sink and its byte monitor
  // ----------------------------------------------------------------------
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    injReady <= 2'($urandom); // sink stalls at random
    for (int p = 0; p < 2; p++)
      if (injValid[p] === 1'b1 && injReady[p] === 1'b1)
        gotQ.push_back({p[0], injSof, injEof, injData});
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one ahb single word transfer; waits on hready at both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // poll status until exactly the channels in m are still armed
  task automatic wait_armed(input logic [3:0] m);
    for (int i = 0; i < 500; i++)
    begin
      ahb(0, 32'h10, 0, rd);
      if (rd[3:0] === m)
        break;
    end
  endtask
  // one-block injection list at b: two bytes at offset 5 of the buffer at b+0x100, data word d
  task automatic inj_block(input logic [31:0] b, input logic [31:0] d);
    i_mem.mem[b >> 2] = 32'h0;
    i_mem.mem[(b >> 2) + 1] = b + 32'h100;
    i_mem.mem[(b >> 2) + 2] = 32'h8;
    i_mem.mem[(b >> 2) + 3] = 32'h00530002;
    i_mem.mem[(b + 32'h104) >> 2] = d;
  endtask
  // one two-byte frame at queue entry k for port p: lanes 1 and 2 of d, start then end flag
  task automatic chk_frame(input int k, input logic p, input logic [31:0] d);
    chk(32'(gotQ[k]), {21'h0, p, 2'b10, d[15:8]});
    chk(32'(gotQ[k + 1]), {21'h0, p, 2'b01, d[23:16]});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(69249));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and an unmapped place
    ahb(0, 32'h04, 0, rd);
    chk(rd, 32'h00000030);
    chk(32'(fcsRw), 32'h3);
    chk(32'(hresp), 32'h0);
    ahb(0, 32'h80, 0, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    // port controls, gaps and watermark reach the queue side
    ahb(1, 32'h04, 32'h000003e5, rd);
    ahb(1, 32'h08, 32'h00000011, rd);
    ahb(1, 32'h00, 32'h00000d00, rd);
    // the last write lands on this edge; look once it has settled
    @(posedge clk_sys);
    chk({hdrIns, injHdr, fcsRw}, 32'h16);
    chk({gap1, gap0, wm}, 32'h110d);
    $display("test config done");
    // injection on channel 2: two bytes at offset 5, one block list
    w = $urandom;
    inj_block(32'h100, w);
    ahb(1, 32'h30, 32'h100, rd);
    wait_armed(4'h0);
    chk(32'(gotQ.size()), 32'd2);
    chk_frame(0, 1'b0, w);
    $display("test injection done");
    // extraction on channel 0: three bytes at offset 1, length written back
    i_mem.mem[32'h300 >> 2] = 32'h0;
    i_mem.mem[32'h304 >> 2] = 32'h400;
    i_mem.mem[32'h308 >> 2] = 32'h8;
    i_mem.mem[32'h30c >> 2] = 32'h00100000;
    i_mem.mem[32'h400 >> 2] = 32'h0;
    w = $urandom;
    ahb(1, 32'h20, 32'h300, rd);
    for (int n = 0; n < 3; n++)
    begin
      @(posedge clk_sys);
      xtrValid <= 2'b01;
      xtrData <= {8'h00, w[8*n+:8]};
      xtrEof <= {1'b0, n == 2};
      do @(posedge clk_sys); while (xtrReady[0] !== 1'b1);
      xtrValid <= 2'b00;
    end
    wait_armed(4'h0);
    chk(i_mem.mem[32'h400 >> 2], {w[23:0], 8'h00});
    chk(i_mem.mem[32'h30c >> 2], 32'h00130003);
    ahb(0, 32'h10, 0, rd);
    chk(32'(rd[3:0]), 32'h0);
    $display("test extraction done");
    // manual mode: nothing moves until asked, then the asked channel, lower one first
    gotQ.delete();
    inj_block(32'h100, w);
    inj_block(32'h500, ~w);
    ahb(1, 32'h00, 32'h00000d01, rd);
    ahb(1, 32'h30, 32'h100, rd);
    ahb(1, 32'h38, 32'h500, rd);
    ahb(1, 32'h0c, 32'h4, rd);
    wait_armed(4'h8);
    chk(32'(gotQ.size()), 32'd2);
    chk_frame(0, 1'b0, w);
    ahb(1, 32'h0c, 32'h8, rd);
    wait_armed(4'h0);
    chk_frame(2, 1'b1, ~w);
    $display("test manual done");
    // strict priority, then a tie: both injection channels get ready in one write
    ahb(1, 32'h00, 32'h00000d00, rd);
    for (int t = 0; t < 2; t++)
    begin
      gotQ.delete();
      ahb(1, 32'h04, 32'h000000e5, rd);
      ahb(1, 32'h34, t ? 32'h0 : 32'h5, rd);
      ahb(1, 32'h30, 32'h100, rd);
      ahb(1, 32'h38, 32'h500, rd);
      ahb(1, 32'h04, 32'h000003e5, rd);
      wait_armed(4'h0);
      chk(32'(gotQ.size()), 32'd4);
      chk_frame(0, t[0], t[0] ? ~w : w);
      chk_frame(2, !t[0], t[0] ? w : ~w);
    end
    $display("test priority done");
    give_verdict();
  end
endmodule
`default_nettype wire
